// >>> hw/ccm_monitor.sv
// The address-and-strobe port and the register addresses were left to the implementer.
`default_nettype none

module ccm_monitor #(
   parameter int EE_BYTES = ccm_pkg::EE_BYTES_DEFAULT
) (
   input  wire logic                             clk_sys,
   input  wire logic                             rst,
   input  wire ccm_pkg::ccm_bus_req_type         bus_req,
   output logic [ccm_pkg::DATA_W-1:0]            bus_rdata,
   input  wire ccm_pkg::ccm_fsm_type             fsm_state,
   input  wire logic                             reset_conditions_active,
   input  wire logic [EE_BYTES-1:0][7:0]         eeprom_bytes,
   input  wire logic [7:0]                       eeprom_reference,
   input  wire logic                             analog_latch_ee_fail,
   output logic [ccm_pkg::NUM_PROT-1:0][7:0]     config_regs,
   output logic                                  safe_request,
   output logic                                  off_request,
   output logic                                  analog_latch_ee_set,
   output logic                                  irq
);

   // ----------------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------------
   localparam int PIDX_W = $clog2(ccm_pkg::NUM_PROT);
   localparam int EIDX_W = (EE_BYTES > 1) ? $clog2(EE_BYTES) : 1;
   localparam logic [PIDX_W-1:0] PROT_LAST_IDX =
      PIDX_W'(ccm_pkg::NUM_PROT - 1);
   localparam logic [EIDX_W-1:0] EE_LAST_IDX = EIDX_W'(EE_BYTES - 1);

   logic                 in_diag;
   logic                 in_active;
   logic                 in_reset;
   logic                 prot_hit;
   logic [PIDX_W-1:0]    prot_sel;
   logic                 wr_prot;
   logic                 wr_prot_refused;
   logic                 wr_expected;
   logic                 wr_control;
   logic                 wr_setup_refused;
   logic                 wr_status;
   logic                 wr_mask;
   logic                 rd_irq;

   assign in_diag   = (fsm_state == ccm_pkg::ST_DIAG);
   assign in_active = (fsm_state == ccm_pkg::ST_ACTIVE);
   assign in_reset  = (fsm_state == ccm_pkg::ST_RESET);

   assign prot_hit  = (bus_req.addr <= ccm_pkg::OFS_PROT_LAST) &&
                      (bus_req.addr[1:0] == 2'b00);
   assign prot_sel  = bus_req.addr[PIDX_W+1:2];

   assign wr_prot         = bus_req.wr && prot_hit && !in_active;
   assign wr_prot_refused = bus_req.wr && prot_hit && in_active;

   // Checksum setup only moves while the controller sits in DIAGNOSTIC.
   assign wr_expected = bus_req.wr && in_diag &&
                        (bus_req.addr == ccm_pkg::OFS_EXPECTED);
   assign wr_control  = bus_req.wr && in_diag &&
                        (bus_req.addr == ccm_pkg::OFS_CONTROL);
   assign wr_setup_refused = bus_req.wr && !in_diag &&
                             ((bus_req.addr == ccm_pkg::OFS_EXPECTED) ||
                              (bus_req.addr == ccm_pkg::OFS_CONTROL));
   assign wr_status   = bus_req.wr &&
                        (bus_req.addr == ccm_pkg::OFS_SAFETY_STATUS);
   assign wr_mask     = bus_req.wr &&
                        (bus_req.addr == ccm_pkg::OFS_IRQ_MASK);
   assign rd_irq      = bus_req.rd &&
                        (bus_req.addr == ccm_pkg::OFS_IRQ_STATUS);

   // ----------------------------------------------------------------------
   // Protected and setup registers
   // ----------------------------------------------------------------------
   logic [7:0]           expected_config_checksum;
   logic                 config_check_enable;
   logic                 eeprom_check_selftest_enable;

   generate
      for (genvar g = 0; g < ccm_pkg::NUM_PROT; g++)
      begin : g_prot
         always_ff @(posedge clk_sys or posedge rst)
         begin
            if (rst)
               config_regs[g] <= ccm_pkg::RST_PROT;
            else if (wr_prot && (prot_sel == PIDX_W'(g)))
               config_regs[g] <= bus_req.wdata[7:0];
         end
      end
   endgenerate

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         expected_config_checksum <= ccm_pkg::RST_EXPECTED;
      else if (wr_expected)
         expected_config_checksum <= bus_req.wdata[7:0];
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         config_check_enable          <= 1'b0;
         eeprom_check_selftest_enable <= 1'b0;
      end
      else if (wr_control)
      begin
         config_check_enable <=
            bus_req.wdata[ccm_pkg::CTL_CONFIG_CHECK_EN];
         eeprom_check_selftest_enable <=
            bus_req.wdata[ccm_pkg::CTL_EE_SELFTEST_EN];
      end
   end

   // ----------------------------------------------------------------------
   // Configuration checksum scan
   // ----------------------------------------------------------------------
   // One byte per clock; a pass over all sixteen registers takes sixteen
   // cycles. A register rewritten mid-pass is seen in the same pass only if the scan has not reached it yet, so
   // software must update the expected value before enabling the check.
   logic [PIDX_W-1:0]    cfg_idx;
   logic [7:0]           cfg_crc;
   logic [7:0]           next_cfg_crc;
   logic                 cfg_pass_end;
   logic                 cfg_mismatch_evt;
   logic [7:0]           cfg_result;

   assign next_cfg_crc = ccm_pkg::crc8_byte(cfg_crc,
                                            config_regs[cfg_idx]);
   assign cfg_pass_end = config_check_enable && (cfg_idx == PROT_LAST_IDX);
   assign cfg_mismatch_evt = cfg_pass_end &&
                             (next_cfg_crc != expected_config_checksum);

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         cfg_idx <= '0;
         cfg_crc <= ccm_pkg::CRC_INIT;
      end
      else if (!config_check_enable)
      begin
         cfg_idx <= '0;
         cfg_crc <= ccm_pkg::CRC_INIT;
      end
      else if (cfg_pass_end)
      begin
         cfg_idx <= '0;
         cfg_crc <= ccm_pkg::CRC_INIT;
      end
      else
      begin
         cfg_idx <= cfg_idx + PIDX_W'(1);
         cfg_crc <= next_cfg_crc;
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         cfg_result <= ccm_pkg::CRC_INIT;
      else if (cfg_pass_end)
         cfg_result <= next_cfg_crc;
   end

   // ----------------------------------------------------------------------
   // EEPROM checksum scan
   // ----------------------------------------------------------------------
   logic [EIDX_W-1:0]    ee_idx;
   logic [7:0]           ee_crc;
   logic [7:0]           next_ee_crc;
   logic                 ee_pass_end;
   logic                 ee_mismatch_evt;
   logic [7:0]           ee_result;

   assign next_ee_crc = ccm_pkg::crc8_byte(ee_crc,
                                           eeprom_bytes[ee_idx]);
   assign ee_pass_end = (ee_idx == EE_LAST_IDX);
   // The self-test forces a mismatch at every pass end while it is on.
   assign ee_mismatch_evt = ee_pass_end &&
                            ((next_ee_crc != eeprom_reference) ||
                             eeprom_check_selftest_enable);

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         ee_idx <= '0;
         ee_crc <= ccm_pkg::CRC_INIT;
      end
      else if (ee_pass_end)
      begin
         ee_idx <= '0;
         ee_crc <= ccm_pkg::CRC_INIT;
      end
      else
      begin
         ee_idx <= ee_idx + EIDX_W'(1);
         ee_crc <= next_ee_crc;
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         ee_result <= ccm_pkg::CRC_INIT;
      else if (ee_pass_end)
         ee_result <= next_ee_crc;
   end

   // ----------------------------------------------------------------------
   // Mismatch flags
   // ----------------------------------------------------------------------
   logic                 config_checksum_mismatch_flag;
   logic                 eeprom_checksum_mismatch_flag;
   logic                 powered_up;
   logic                 restore_evt;

   // The analog latch level is caught on the first clock after release.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         powered_up <= 1'b0;
      else
         powered_up <= 1'b1;
   end

   assign restore_evt = !powered_up && analog_latch_ee_fail;

   // Set wins over a write-one-to-clear in the same cycle.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         config_checksum_mismatch_flag <= 1'b0;
      else if (cfg_mismatch_evt)
         config_checksum_mismatch_flag <= 1'b1;
      else if (wr_status && bus_req.wdata[ccm_pkg::STS_CONFIG_MISMATCH])
         config_checksum_mismatch_flag <= 1'b0;
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         eeprom_checksum_mismatch_flag <= 1'b0;
      else if (ee_mismatch_evt || restore_evt)
         eeprom_checksum_mismatch_flag <= 1'b1;
      else if (wr_status && bus_req.wdata[ccm_pkg::STS_EEPROM_MISMATCH])
         eeprom_checksum_mismatch_flag <= 1'b0;
   end

   // ----------------------------------------------------------------------
   // State requests to the fail-safe controller
   // ----------------------------------------------------------------------
   // RESET has priority: a pending SAFE request is held back until the
   // reset conditions are gone, then released.
   assign safe_request = config_checksum_mismatch_flag &&
                         ((in_reset && !reset_conditions_active) ||
                          in_diag || in_active);

   // The self-test must not shut the device down, so it sets the flag and the interrupt status bit but raises no off request.
   assign off_request = eeprom_checksum_mismatch_flag &&
                        !eeprom_check_selftest_enable &&
                        (in_reset || in_diag || in_active ||
                         (fsm_state == ccm_pkg::ST_SAFE));
   assign analog_latch_ee_set = off_request;

   // ----------------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------------
   logic [ccm_pkg::IRQ_W-1:0] irq_status;
   logic [ccm_pkg::IRQ_W-1:0] irq_mask;
   logic [ccm_pkg::IRQ_W-1:0] irq_events;

   assign irq_events[ccm_pkg::IRQ_CONFIG_MISMATCH] = cfg_mismatch_evt;
   assign irq_events[ccm_pkg::IRQ_EEPROM_MISMATCH] = ee_mismatch_evt ||
                                                      restore_evt;
   assign irq_events[ccm_pkg::IRQ_WRITE_REFUSED]   = wr_prot_refused ||
                                                      wr_setup_refused;

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         irq_status <= '0;
      else if (rd_irq)
         irq_status <= irq_events;
      else
         irq_status <= irq_status | irq_events;
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         irq_mask <= ccm_pkg::RST_IRQ_MASK;
      else if (wr_mask)
         irq_mask <= bus_req.wdata[ccm_pkg::IRQ_W-1:0];
   end

   assign irq = |(irq_status & irq_mask);

   // ----------------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------------
   logic [ccm_pkg::DATA_W-1:0] next_rdata;

   always_comb
   begin
      next_rdata = '0;
      if (bus_req.rd)
      begin
         if (prot_hit)
            next_rdata[7:0] = config_regs[prot_sel];
         else
         begin
            case (bus_req.addr)
               ccm_pkg::OFS_EXPECTED:
                  next_rdata[7:0] = expected_config_checksum;
               ccm_pkg::OFS_CONTROL:
               begin
                  next_rdata[ccm_pkg::CTL_CONFIG_CHECK_EN] =
                     config_check_enable;
                  next_rdata[ccm_pkg::CTL_EE_SELFTEST_EN] =
                     eeprom_check_selftest_enable;
               end
               ccm_pkg::OFS_SAFETY_STATUS:
               begin
                  next_rdata[ccm_pkg::STS_CONFIG_MISMATCH] =
                     config_checksum_mismatch_flag;
                  next_rdata[ccm_pkg::STS_EEPROM_MISMATCH] =
                     eeprom_checksum_mismatch_flag;
               end
               ccm_pkg::OFS_IRQ_STATUS:
                  next_rdata[ccm_pkg::IRQ_W-1:0] = irq_status;
               ccm_pkg::OFS_IRQ_MASK:
                  next_rdata[ccm_pkg::IRQ_W-1:0] = irq_mask;
               ccm_pkg::OFS_CONFIG_RESULT:
                  next_rdata[7:0] = cfg_result;
               ccm_pkg::OFS_EEPROM_RESULT:
                  next_rdata[7:0] = ee_result;
               default:
                  next_rdata = '0;
            endcase
         end
      end
   end

   // Data stands only in the cycle after the read strobe.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         bus_rdata <= '0;
      else
         bus_rdata <= next_rdata;
   end

endmodule

`default_nettype wire

// >>> hw/ccm_pkg.sv
`default_nettype none

package ccm_pkg;

   // ----------------------------------------------------------------------
   // Register bus
   // ----------------------------------------------------------------------
   localparam int          ADDR_W = 8;
   localparam int          DATA_W = 32;
   localparam int          REG_W  = 8;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } ccm_bus_req_type;

   // ----------------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------------
   localparam int          NUM_PROT            = 16;
   localparam logic [7:0]  OFS_PROT_BASE       = 8'h00;
   localparam logic [7:0]  OFS_PROT_LAST       = 8'h3c;
   localparam logic [7:0]  OFS_EXPECTED        = 8'h40;
   localparam logic [7:0]  OFS_CONTROL         = 8'h44;
   localparam logic [7:0]  OFS_SAFETY_STATUS   = 8'h48;
   localparam logic [7:0]  OFS_IRQ_STATUS      = 8'h4c;
   localparam logic [7:0]  OFS_IRQ_MASK        = 8'h50;
   localparam logic [7:0]  OFS_CONFIG_RESULT   = 8'h54;
   localparam logic [7:0]  OFS_EEPROM_RESULT   = 8'h58;

   // Field positions.
   localparam int          CTL_CONFIG_CHECK_EN = 0;
   localparam int          CTL_EE_SELFTEST_EN  = 1;
   localparam int          STS_CONFIG_MISMATCH = 0;
   localparam int          STS_EEPROM_MISMATCH = 1;
   localparam int          IRQ_CONFIG_MISMATCH = 0;
   localparam int          IRQ_EEPROM_MISMATCH = 1;
   localparam int          IRQ_WRITE_REFUSED   = 2;
   localparam int          IRQ_W               = 3;

   // Reset values.
   localparam logic [7:0]  RST_PROT            = 8'h00;
   localparam logic [7:0]  RST_EXPECTED        = 8'h00;
   localparam logic [IRQ_W-1:0] RST_IRQ_MASK   = 3'h0;

   // ----------------------------------------------------------------------
   // Checksum
   // ----------------------------------------------------------------------
   localparam logic [7:0]  CRC_POLY            = 8'h07;
   localparam logic [7:0]  CRC_INIT            = 8'hff;
   localparam int          EE_BYTES_DEFAULT    = 16;

   // Fail-safe controller state as reported to this block.
   typedef enum logic [5:0] {
      ST_OFF    = 6'h01,
      ST_INIT   = 6'h02,
      ST_RESET  = 6'h04,
      ST_DIAG   = 6'h08,
      ST_ACTIVE = 6'h10,
      ST_SAFE   = 6'h20
   } ccm_fsm_type;

   // One byte through the CRC, most significant bit first.
   function automatic logic [7:0] crc8_byte(input logic [7:0] crc_in,
                                            input logic [7:0] data);
      logic [7:0] c;
      logic       fb;
      c  = crc_in;
      fb = 1'b0;
      for (int i = 7; i >= 0; i--)
      begin
         fb = c[7] ^ data[i];
         c  = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
      end
      return c;
   endfunction

endpackage

`default_nettype wire

// >>> verif/ccm_monitor_props.sv
`default_nettype none

module ccm_monitor_props (
   input wire logic                             clk_sys,
   input wire logic                             rst,
   input wire ccm_pkg::ccm_bus_req_type         bus_req,
   input wire logic [ccm_pkg::DATA_W-1:0]       bus_rdata,
   input wire ccm_pkg::ccm_fsm_type             fsm_state,
   input wire logic                             reset_conditions_active,
   input wire logic [ccm_pkg::NUM_PROT-1:0][7:0] config_regs,
   input wire logic                             safe_request,
   input wire logic                             off_request,
   input wire logic                             analog_latch_ee_set
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   logic prot_wr;
   logic cfg_clr;

   assign prot_wr = bus_req.wr && bus_req.addr <= ccm_pkg::OFS_PROT_LAST;
   assign cfg_clr = bus_req.wr && bus_req.addr == ccm_pkg::OFS_SAFETY_STATUS
                    && bus_req.wdata[ccm_pkg::STS_CONFIG_MISMATCH];

   // A raised request with nothing around it changing must not drop.
   sequence held_flag;
      safe_request && !cfg_clr ##1
         $stable(fsm_state) && $stable(reset_conditions_active);
   endsequence

   a_rdata_idle:
      assert property (!$past(bus_req.rd) |-> bus_rdata == '0)
      else $error("read data outside the answer cycle");
   a_latch_follow:
      assert property (analog_latch_ee_set == off_request)
      else $error("failure latch set differs from off request");
   a_off_states:
      assert property (off_request |-> fsm_state != ccm_pkg::ST_OFF
                       && fsm_state != ccm_pkg::ST_INIT)
      else $error("off request outside operating states");
   a_safe_states:
      assert property (safe_request |-> fsm_state inside
                       {ccm_pkg::ST_DIAG, ccm_pkg::ST_ACTIVE, ccm_pkg::ST_RESET})
      else $error("safe request outside allowed states");
   a_reset_wait:
      assert property (fsm_state == ccm_pkg::ST_RESET
                       && reset_conditions_active |-> !safe_request)
      else $error("safe request while reset conditions persist");
   a_active_lock:
      assert property (prot_wr && fsm_state == ccm_pkg::ST_ACTIVE
                       |=> $stable(config_regs))
      else $error("protected register changed in active state");
   a_prot_write:
      assert property (prot_wr && fsm_state != ccm_pkg::ST_ACTIVE
                       && bus_req.addr[1:0] == 2'h0
                       |=> config_regs[$past(bus_req.addr[5:2])]
                           == $past(bus_req.wdata[7:0]))
      else $error("protected register write lost");
   a_flag_sticky:
      assert property (held_flag |-> safe_request)
      else $error("safe request dropped without a clear");
endmodule

bind ccm_monitor ccm_monitor_props chk_u (
   .clk_sys                 (clk_sys),
   .rst                     (rst),
   .bus_req                 (bus_req),
   .bus_rdata               (bus_rdata),
   .fsm_state               (fsm_state),
   .reset_conditions_active (reset_conditions_active),
   .config_regs             (config_regs),
   .safe_request            (safe_request),
   .off_request             (off_request),
   .analog_latch_ee_set     (analog_latch_ee_set)
);

`default_nettype wire

// >>> verif/ccm_mcu_model.sv
`default_nettype none

module ccm_mcu_model (
   input  wire logic                       clk_sys,
   input  wire logic [ccm_pkg::DATA_W-1:0] bus_rdata,
   output var  ccm_pkg::ccm_bus_req_type   bus_req
);
   timeunit 1ns;
   timeprecision 1ns;

   initial bus_req = '0;

   // Released write data is scrambled so a stale value never looks valid.
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      bus_req <= '{addr: a, wdata: {24'h0, d}, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      bus_req.wr    <= 1'b0;
      bus_req.wdata <= ~{24'h0, d};
      @(negedge clk_sys);
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      bus_req.rd <= 1'b0;
      @(negedge clk_sys);
      d = bus_rdata;
   endtask

   task automatic arm_check(input logic [7:0] expected);
      wr_reg(ccm_pkg::OFS_EXPECTED, expected);
      wr_reg(ccm_pkg::OFS_CONTROL, 8'h01);
   endtask

   task automatic clear_flags(input logic [7:0] bits);
      wr_reg(ccm_pkg::OFS_SAFETY_STATUS, bits);
   endtask
endmodule

`default_nettype wire

// >>> verif/tb.sv
`default_nettype none
`define CHK(got, exp) \
   begin \
      checked++; \
      if ((got) !== (exp)) \
      begin \
         n_errors++; \
         $display("mismatch at %0t: got %h want %h", $time, got, exp); \
      end \
   end

module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int EE = 4;
   localparam int CFG_WAIT = 34;
   localparam int EE_WAIT = 2 * EE + 2;

   logic                     clk_sys;
   logic                     rst;
   ccm_pkg::ccm_bus_req_type bus_req;
   logic [31:0]              bus_rdata;
   ccm_pkg::ccm_fsm_type     fsm_state;
   logic                     rca;
   logic [EE-1:0][7:0]       ee_bytes;
   logic [7:0]               ee_ref;
   logic                     latch_fail;
   logic [15:0][7:0]         cfg_regs;
   logic                     safe_req;
   logic                     off_req;
   logic                     latch_set;
   logic                     irq;
   int                       n_errors = 0;
   int                       checked = 0;
   int                       cycles = 0;
   logic [31:0]              rdv;
   logic [7:0]               good_ee;
   logic [7:0]               cfg_crc;
   logic [15:0][7:0]         prot;

   ccm_monitor #(.EE_BYTES(EE)) dut_u (
      .clk_sys                 (clk_sys),
      .rst                     (rst),
      .bus_req                 (bus_req),
      .bus_rdata               (bus_rdata),
      .fsm_state               (fsm_state),
      .reset_conditions_active (rca),
      .eeprom_bytes            (ee_bytes),
      .eeprom_reference        (ee_ref),
      .analog_latch_ee_fail    (latch_fail),
      .config_regs             (cfg_regs),
      .safe_request            (safe_req),
      .off_request             (off_req),
      .analog_latch_ee_set     (latch_set),
      .irq                     (irq)
   );

   ccm_mcu_model mcu_u (
      .clk_sys   (clk_sys),
      .bus_rdata (bus_rdata),
      .bus_req   (bus_req)
   );

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   function automatic logic [7:0] ref_crc(input logic [7:0] c,
                                          input logic [7:0] d);
      for (int i = 7; i >= 0; i--)
         c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
      return c;
   endfunction

   task automatic end_of_test;
      if (n_errors == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic check_rd(input logic [7:0] a, input logic [31:0] exp);
      mcu_u.rd_reg(a, rdv);
      `CHK(rdv, exp)
   endtask

   task automatic set_env(input ccm_pkg::ccm_fsm_type s, input logic c,
                          input logic [7:0] r);
      @(posedge clk_sys);
      fsm_state <= s;
      rca       <= c;
      ee_ref    <= r;
      @(negedge clk_sys);
   endtask

   task automatic do_reset(input logic f);
      @(posedge clk_sys);
      rst        <= 1'b1;
      latch_fail <= f;
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
   endtask

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   task automatic t_reset_values;
      check_rd(ccm_pkg::OFS_EXPECTED, 32'h0);
      check_rd(ccm_pkg::OFS_CONTROL, 32'h0);
      check_rd(8'h3c, 32'h0);
      check_rd(8'hfc, 32'h0);
      `CHK(irq, 1'b0)
   endtask

   task automatic t_config_pass;
      cfg_crc = 8'hff;
      for (int i = 0; i < 16; i++)
      begin
         prot[i] = 8'h5a ^ (8'(i) * 8'h13);
         mcu_u.wr_reg(8'(i * 4), prot[i]);
         cfg_crc = ref_crc(cfg_crc, prot[i]);
      end
      mcu_u.arm_check(cfg_crc);
      repeat (CFG_WAIT) @(posedge clk_sys);
      check_rd(ccm_pkg::OFS_CONFIG_RESULT, {24'h0, cfg_crc});
      check_rd(ccm_pkg::OFS_SAFETY_STATUS, 32'h0);
      `CHK(cfg_regs, prot)
   endtask

   task automatic t_config_mismatch;
      mcu_u.wr_reg(ccm_pkg::OFS_IRQ_MASK, 8'h01);
      mcu_u.wr_reg(8'h00, ~prot[0]);
      repeat (CFG_WAIT) @(posedge clk_sys);
      `CHK(safe_req, 1'b1)
      check_rd(ccm_pkg::OFS_SAFETY_STATUS, 32'h1);
      `CHK(irq, 1'b1)
      mcu_u.wr_reg(ccm_pkg::OFS_IRQ_MASK, 8'h06);
      `CHK(irq, 1'b0)
      mcu_u.wr_reg(ccm_pkg::OFS_CONTROL, 8'h00);
      check_rd(ccm_pkg::OFS_IRQ_STATUS, 32'h1);
      check_rd(ccm_pkg::OFS_IRQ_STATUS, 32'h0);
      mcu_u.wr_reg(8'h00, prot[0]);
      mcu_u.wr_reg(ccm_pkg::OFS_CONTROL, 8'h01);
      repeat (CFG_WAIT) @(posedge clk_sys);
      check_rd(ccm_pkg::OFS_SAFETY_STATUS, 32'h1);
      mcu_u.clear_flags(8'h01);
      repeat (CFG_WAIT) @(posedge clk_sys);
      check_rd(ccm_pkg::OFS_SAFETY_STATUS, 32'h0);
      `CHK(safe_req, 1'b0)
   endtask

   task automatic t_state_locks;
      set_env(ccm_pkg::ST_ACTIVE, 1'b0, good_ee);
      mcu_u.wr_reg(8'h04, ~prot[1]);
      mcu_u.wr_reg(ccm_pkg::OFS_EXPECTED, ~cfg_crc);
      check_rd(8'h04, {24'h0, prot[1]});
      check_rd(ccm_pkg::OFS_EXPECTED, {24'h0, cfg_crc});
      `CHK(irq, 1'b1)
      check_rd(ccm_pkg::OFS_IRQ_STATUS, 32'h4);
      `CHK(irq, 1'b0)
      set_env(ccm_pkg::ST_DIAG, 1'b0, good_ee);
      mcu_u.wr_reg(ccm_pkg::OFS_EXPECTED, ~cfg_crc);
      repeat (CFG_WAIT) @(posedge clk_sys);
      set_env(ccm_pkg::ST_RESET, 1'b1, good_ee);
      `CHK(safe_req, 1'b0)
      set_env(ccm_pkg::ST_RESET, 1'b0, good_ee);
      `CHK(safe_req, 1'b1)
      set_env(ccm_pkg::ST_DIAG, 1'b0, good_ee);
      mcu_u.arm_check(cfg_crc);
      mcu_u.clear_flags(8'h01);
      repeat (CFG_WAIT) @(posedge clk_sys);
      check_rd(ccm_pkg::OFS_SAFETY_STATUS, 32'h0);
   endtask

   task automatic t_eeprom;
      ccm_pkg::ccm_fsm_type sts [5];
      sts = '{ccm_pkg::ST_SAFE, ccm_pkg::ST_RESET, ccm_pkg::ST_ACTIVE,
              ccm_pkg::ST_OFF, ccm_pkg::ST_DIAG};
      set_env(ccm_pkg::ST_DIAG, 1'b0, good_ee ^ 8'h01);
      repeat (EE_WAIT) @(posedge clk_sys);
      `CHK(latch_set, 1'b1)
      check_rd(ccm_pkg::OFS_EEPROM_RESULT, {24'h0, good_ee});
      check_rd(ccm_pkg::OFS_SAFETY_STATUS, 32'h2);
      for (int i = 0; i < 5; i++)
      begin
         set_env(sts[i], 1'b0, good_ee);
         `CHK(off_req, sts[i] != ccm_pkg::ST_OFF)
      end
      repeat (EE_WAIT) @(posedge clk_sys);
      `CHK(off_req, 1'b1)
      mcu_u.clear_flags(8'h02);
      repeat (EE_WAIT) @(posedge clk_sys);
      `CHK(off_req, 1'b0)
      mcu_u.wr_reg(ccm_pkg::OFS_CONTROL, 8'h03);
      repeat (EE_WAIT) @(posedge clk_sys);
      check_rd(ccm_pkg::OFS_SAFETY_STATUS, 32'h2);
      mcu_u.wr_reg(ccm_pkg::OFS_CONTROL, 8'h01);
      mcu_u.clear_flags(8'h02);
      check_rd(ccm_pkg::OFS_SAFETY_STATUS, 32'h0);
   endtask

   task automatic t_power_up;
      do_reset(1'b1);
      check_rd(ccm_pkg::OFS_SAFETY_STATUS, 32'h2);
      do_reset(1'b0);
      check_rd(ccm_pkg::OFS_SAFETY_STATUS, 32'h0);
   endtask

   // ----------------------------------------------------------------------
   // Run
   // ----------------------------------------------------------------------
   initial
   begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   // The whole run needs well under two thousand cycles.
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_errors++;
         end_of_test();
      end
   end

   initial
   begin
      rst        = 1'b1;
      fsm_state  = ccm_pkg::ST_DIAG;
      rca        = 1'b0;
      latch_fail = 1'b0;
      good_ee    = 8'hff;
      for (int i = 0; i < EE; i++)
      begin
         ee_bytes[i] = 8'(i) * 8'h21 + 8'h03;
         good_ee     = ref_crc(good_ee, ee_bytes[i]);
      end
      ee_ref = good_ee;
      do_reset(1'b0);
      t_reset_values();
      t_config_pass();
      t_config_mismatch();
      t_state_locks();
      t_eeprom();
      t_power_up();
      end_of_test();
   end
endmodule

`default_nettype wire
